//--- logic/lsm_pwm.sv
// fixed-frequency dimming pwm generator
`timescale 1ns/1ps
`include "lsm_regs.svh"
module lsm_pwm #(
  parameter int PERIOD = `LSM_PWM_PERIOD,
  parameter int DW     = `LSM_DUTY_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [DW-1:0] duty,
  output logic               pwm_on
);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0]      cnt;
  logic [CW+DW-1:0]   thresh;
  wire  last_tick = (cnt == CW'(PERIOD - 1));

  // duty scaled to the period: on while cnt*2^DW < duty*PERIOD
  assign thresh = (CW+DW)'(duty) * (CW+DW)'(PERIOD);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt    <= '0;
      pwm_on <= 1'b0;
    end else begin
      cnt    <= last_tick ? '0 : cnt + 1'b1;
      pwm_on <= ({cnt, {DW{1'b0}}} < thresh);
    end
  end
endmodule : lsm_pwm

//--- logic/lsm_top.sv
// mode, dimming and fault control of the eight-channel led string driver
`timescale 1ns/1ps
`include "lsm_regs.svh"
// Behaviour
// - brake mode high drives all enabled channels at full duty.
// - brake mode low dims all channels together at the set duty.
// - dimming comes from a fixed 800 Hz internal pwm.
// - latch-off variant: any single open channel latches all eight off.
// - latch clears on fault pin low, enable toggle, or supply undervoltage.
// - open-load detection off until supply is above the disable threshold.
// - channel is open when its current is at half of target.
// - fault output released high on any open string or set-resistor overcurrent, low otherwise.
// - open-string faults reported only while outputs are driven; overcurrent is reported at any time.
// - channels grounded at power-up never report open circuit.
// - set-resistor overcurrent reduces current and releases fault high.
module lsm_top
  import lsm_pkg::*;
#(
  parameter bit LATCH_OFF = 1'b1,
  parameter int NCH       = `LSM_NCH,
  parameter int DW        = `LSM_DUTY_W
) (
  input  wire logic                       MCLK,
  input  wire logic                       RST_N,
  input  wire logic                       BRAKE_MODE,
  input  wire logic                       ENABLE,
  input  wire logic [DW-1:0]              DIM_DUTY,
  input  wire lsm_pkg::lsm_sense_t [NCH-1:0] CHANNEL_SENSE,
  input  wire lsm_pkg::lsm_supply_t       SUPPLY,
  input  wire logic                       SET_OVERCURRENT,
  input  wire logic                       FAULT_PIN_LOW,
  output logic [NCH-1:0]                  CHANNEL_OUTPUT,
  output logic                            CURRENT_REDUCE,
  output logic                            FAULT_OUT,
  output logic                            FAULT_OE,
  output logic [NCH-1:0]                  CHANNEL_UNUSED,
  output logic                            LATCHED_OFF
);
  import lsm_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int SW = 4 + 2*NCH + 2;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  wire  [SW-1:0] raw_in = {BRAKE_MODE, ENABLE, SET_OVERCURRENT,
                           FAULT_PIN_LOW, CHANNEL_SENSE, SUPPLY};

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire               brake_s  = sync2[SW-1];
  wire               enable_s = sync2[SW-2];
  wire               ocur_s   = sync2[SW-3];
  wire               fpin_s   = sync2[SW-4];
  lsm_sense_t [NCH-1:0] sense_s;
  lsm_supply_t       supply_s;
  assign sense_s  = sync2[SW-5:2];
  assign supply_s = sync2[1:0];

  // ------------------------------------------------------------
  // dimming pwm
  // ------------------------------------------------------------
  logic pwm_on;
  lsm_pwm #(
    .DW (DW)
  ) u_pwm (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .duty   (DIM_DUTY),  // from a static resistor setting
    .pwm_on (pwm_on)
  );

  // ------------------------------------------------------------
  // control state
  // ------------------------------------------------------------
  lsm_state_t       state;
  lsm_state_t       next_state;
  logic             enable_d;
  logic [NCH-1:0]   unused;
  logic [NCH-1:0]   next_unused;

  wire enable_toggle = enable_s ^ enable_d;
  wire olt_ok        = supply_s.above_olt;
  wire uvlo_low      = !supply_s.above_uvlo;
  wire drive_phase   = enable_s && (brake_s || pwm_on);
  // no open report before the unused mask has been captured
  wire powerup       = (state == LSM_POWERUP);

  // per-channel open detection
  logic [NCH-1:0] open_ch;
  logic [NCH-1:0] grounded;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign open_ch[g]  = sense_s[g].below_half && !unused[g] && olt_ok &&
                           !powerup;
      assign grounded[g] = sense_s[g].tied_low;
    end
  endgenerate

  wire any_open   = |open_ch;
  wire clear_evt  = fpin_s || enable_toggle || uvlo_low;
  wire latch_trip = LATCH_OFF && any_open && drive_phase;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_unused = unused;
    case (state)
      LSM_POWERUP: begin
        // classify grounded channels once supply passes threshold
        if (olt_ok) begin
          next_unused = grounded;
          next_state  = LSM_RUN;
        end
      end
      LSM_RUN: begin
        if (uvlo_low) begin
          next_state = LSM_POWERUP;
        end else if (latch_trip) begin
          next_state = LSM_LATCHED;
        end
      end
      LSM_LATCHED: begin
        if (uvlo_low) begin
          next_state = LSM_POWERUP;
        end else if (clear_evt) begin
          next_state = LSM_RUN;
        end
      end
      default: begin
        next_state = LSM_POWERUP;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= LSM_POWERUP;
      unused   <= '0;
      enable_d <= 1'b0;
    end else begin
      state    <= next_state;
      unused   <= next_unused;
      enable_d <= enable_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  wire latched   = (state == LSM_LATCHED);
  wire drive_now = drive_phase && !latched;
  // open string only counted during drive-on phases
  wire fault_now = (any_open && drive_now) || ocur_s;

  logic [NCH-1:0] next_chan;
  assign next_chan = drive_now ? ~unused : `LSM_CH_ALL_OFF;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CHANNEL_OUTPUT <= '0;
      CURRENT_REDUCE <= 1'b0;
      FAULT_OUT      <= 1'b0;
      FAULT_OE       <= 1'b1;
      CHANNEL_UNUSED <= '0;
      LATCHED_OFF    <= 1'b0;
    end else begin
      CHANNEL_OUTPUT <= next_chan;
      CURRENT_REDUCE <= ocur_s;
      // open drain: pull low unless a fault is present
      FAULT_OUT      <= 1'b0;
      FAULT_OE       <= !fault_now;
      CHANNEL_UNUSED <= unused;
      LATCHED_OFF    <= latched;
    end
  end
endmodule : lsm_top

//--- pkg/lsm_pkg.sv
// types for the led string mode and fault logic
package lsm_pkg;
  typedef enum logic [2:0] {
    LSM_POWERUP = 3'b001,
    LSM_RUN     = 3'b010,
    LSM_LATCHED = 3'b100
  } lsm_state_t;

  // analog comparator flags for one channel
  typedef struct packed {
    logic below_half;   // monitored current at or under half target
    logic tied_low;     // channel output held at ground
  } lsm_sense_t;

  // supply comparator levels
  typedef struct packed {
    logic above_uvlo;
    logic above_olt;    // above the open-load disable threshold
  } lsm_supply_t;
endpackage : lsm_pkg

//--- pkg/lsm_regs.svh
// timing counts and field constants for the led string mode and fault logic
`ifndef LSM_REGS_SVH
`define LSM_REGS_SVH
`define LSM_CLK_HZ        40000000
`define LSM_PWM_HZ        800
`define LSM_PWM_PERIOD    (`LSM_CLK_HZ / `LSM_PWM_HZ)
`define LSM_DUTY_W        8
`define LSM_DUTY_FULL     8'hff
`define LSM_NCH           8
`define LSM_CH_ALL_OFF    8'h00
`define LSM_CH_ALL_ON     8'hff
`endif

//--- tb/lsm_host_model.sv
// host side of the open-drain fault line
`timescale 1ns/1ps
module lsm_host_model (
  input  wire logic MCLK,
  input  wire logic fault_oe,
  input  wire logic fault_out,
  input  wire logic clear_req,
  output logic      fault_pin_low = 1'b0,
  output logic      fault_seen
);
  // pull-up: a released line reads high, the fault level
  assign fault_seen = fault_oe ? fault_out : 1'b1;
  always @(posedge MCLK) fault_pin_low <= clear_req;
endmodule : lsm_host_model

//--- tb/lsm_top_monitor.sv
// assertions on the led string control ports
`timescale 1ns/1ps
module lsm_top_monitor
  import lsm_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic       BRAKE_MODE,
  input wire logic       ENABLE,
  input wire lsm_pkg::lsm_supply_t SUPPLY,
  input wire logic       SET_OVERCURRENT,
  input wire logic [7:0] CHANNEL_OUTPUT,
  input wire logic       CURRENT_REDUCE,
  input wire logic       FAULT_OE,
  input wire logic [7:0] CHANNEL_UNUSED,
  input wire logic       LATCHED_OFF
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  AST_LATCH_ALL: assert property (LATCHED_OFF |-> !CHANNEL_OUTPUT)
    else $error("latched but driving");
  AST_UNUSED: assert property (!(CHANNEL_OUTPUT & CHANNEL_UNUSED))
    else $error("unused channel driven");
  AST_FULL_ON: assert property (
    (BRAKE_MODE && ENABLE && !LATCHED_OFF && SUPPLY == 2'b11)[*5] |->
    CHANNEL_OUTPUT == ~CHANNEL_UNUSED)
    else $error("full drive missing");
  AST_EN_OFF: assert property ((!ENABLE)[*5] |-> !CHANNEL_OUTPUT)
    else $error("disabled but driving");
  AST_REDUCE: assert property ($rose(SET_OVERCURRENT) |-> ##[2:4]
    CURRENT_REDUCE)
    else $error("no current reduce");
  AST_OC_FAULT: assert property (SET_OVERCURRENT[*5] |-> !FAULT_OE)
    else $error("overcurrent not flagged");
  AST_NO_DETECT: assert property ((!SUPPLY.above_olt &&
    !SET_OVERCURRENT)[*5] |-> FAULT_OE)
    else $error("fault below threshold");
  AST_DRIVEN: assert property (!FAULT_OE |->
    CHANNEL_OUTPUT != 8'h00 || CURRENT_REDUCE)
    else $error("fault while not driving");
  COV_LATCH: cover property ($rose(LATCHED_OFF));
  COV_OC: cover property ($rose(CURRENT_REDUCE));
  COV_FAULT: cover property ($fell(FAULT_OE));
endmodule : lsm_top_monitor
bind lsm_top lsm_top_monitor i_mon (.*);

//--- tb/lsm_top_tb.sv
// self-checking bench for the led string mode and fault control
`timescale 1ns/1ps
`include "lsm_regs.svh"
module lsm_top_tb;
  import lsm_pkg::*;
  typedef logic [9:0] lsm_exp_t;
  logic MCLK = 0, RST_N = 0, BRAKE_MODE = 1, ENABLE = 0, clear_req = 0;
  logic SET_OVERCURRENT = 0, FAULT_PIN_LOW, fault_seen, CURRENT_REDUCE;
  logic FAULT_OUT, FAULT_OE, LATCHED_OFF;
  logic [7:0] DIM_DUTY = 0, CHANNEL_OUTPUT, CHANNEL_UNUSED;
  lsm_sense_t [7:0] CHANNEL_SENSE = 16'h4000;
  lsm_supply_t SUPPLY = 2'b10;
  lsm_exp_t exp_q[$];
  int num_errors = 0, checked = 0, n;
  logic [31:0] rnd = 32'h3ff79919;
  always #12.5 MCLK = ~MCLK;
  lsm_top i_dut (.*);
  lsm_host_model i_host (.MCLK(MCLK), .fault_oe(FAULT_OE),
    .fault_out(FAULT_OUT), .clear_req(clear_req),
    .fault_pin_low(FAULT_PIN_LOW), .fault_seen(fault_seen));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic cyc(int k);
    repeat (k) @(posedge MCLK);
  endtask : cyc
  task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0d exp %0d", $time, got, exp);
    end
  endtask : cmp_val
  // note the expected outputs, channel mask then fault enable and latch
  task automatic note(lsm_exp_t e);
    cyc(8);
    exp_q.push_back(e);
  endtask : note
  task automatic wait_fault;
    for (n = 0; n < 8 && fault_seen !== 1'b1; n++) @(negedge MCLK);
    cmp_val(fault_seen, 1);
  endtask : wait_fault
  always @(negedge MCLK) begin
    if (exp_q.size() > 0)
      cmp_val({CHANNEL_OUTPUT, FAULT_OE, LATCHED_OFF},
              exp_q.pop_front());
  end
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    cyc(2);
    RST_N <= 1'b1;
    ENABLE <= 1'b1;
    CHANNEL_SENSE[3].below_half <= 1'b1;
    note({8'hff, 2'b10});
    SUPPLY <= 2'b11;
    CHANNEL_SENSE[3] <= 2'b00;
    note({8'h7f, 2'b10});
    CHANNEL_SENSE[7] <= 2'b10;
    note({8'h7f, 2'b10});
    for (int m = 0; m < 3; m++) begin
      rnd = xs(rnd);
      CHANNEL_SENSE[rnd % 7].below_half <= 1'b1;
      wait_fault;
      note({8'h00, 2'b11});
      CHANNEL_SENSE <= '0;
      clear_req <= (m == 0);
      ENABLE <= (m != 1);
      SUPPLY <= (m == 2) ? 2'b00 : 2'b11;
      cyc(4);
      clear_req <= 1'b0;
      ENABLE <= 1'b1;
      SUPPLY <= 2'b11;
      note({(m == 2) ? 8'hff : 8'h7f, 2'b10});
    end
    SET_OVERCURRENT <= 1'b1;
    wait_fault;
    note({8'hff, 2'b00});
    SET_OVERCURRENT <= 1'b0;
    rnd = xs(rnd);
    DIM_DUTY <= rnd[6:0] + 8'h01;
    BRAKE_MODE <= 1'b0;
    for (n = 0; n < 60000 && CHANNEL_OUTPUT !== 8'h00; n++) @(negedge MCLK);
    for (n = 0; n < 60000 && CHANNEL_OUTPUT !== 8'hff; n++) @(negedge MCLK);
    for (n = 0; n < 60000 && CHANNEL_OUTPUT === 8'hff; n++) @(negedge MCLK);
    cmp_val(n, (DIM_DUTY * `LSM_PWM_PERIOD + 255) / 256);
    cyc(2);
    summarize;
  end
  initial begin
    cyc(90000);
    num_errors++;
    summarize;
  end
endmodule : lsm_top_tb
